// ### src/sio_tx_port.sv
// Synchronous serial port: clock source, shift edges, bit order and the
// transmit path, reached by software over an AHB-Lite slave.
// Assumes one master, single word transfers, and an external pin buffer
// that resolves the clock pin from sck_out and sck_oe.
`timescale 1ns/1ps
module sio_tx_port #(
  parameter int FS_DIV = sio_pkg::FS_DIV
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  output logic serial_irq
);
  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic [7:0] a_idx_r;
  logic a_wr_r;
  logic a_rd;
  logic a_go;
  logic [7:0] idx_nxt;
  sio_pkg::ctrl_t ctrl_r;
  sio_pkg::stat_t stat_r;
  logic div_src_r;
  logic low_speed_r;
  logic [7:0] tx_buf_r;
  logic [7:0] rx_buf_r;
  logic rx_full_r;

  // Word index from the byte address
  assign idx_nxt = haddr[9:2];
  assign a_go = hsel && hready && htrans[1];
  assign a_rd = a_go && !hwrite;
  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; write strobe lives only in the data phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      a_idx_r <= 8'h00;
      a_wr_r <= 1'b0;
    end else begin
      a_idx_r <= idx_nxt;
      a_wr_r <= a_go && hwrite;
    end
  end

  // Write decode, used by several processes
  function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
                                  input logic [7:0] want);
    wr_hit = wr && (idx == want);
  endfunction

  logic wr_ctrl;
  logic wr_stat;
  logic wr_buf;
  logic force_stop;
  assign wr_ctrl = wr_hit(a_wr_r, a_idx_r, sio_pkg::CTRL_IDX);
  assign wr_stat = wr_hit(a_wr_r, a_idx_r, sio_pkg::STAT_IDX);
  assign wr_buf = wr_hit(a_wr_r, a_idx_r, sio_pkg::BUF_IDX);
  assign force_stop = wr_ctrl && hwdata[sio_pkg::CTRL_STOP_BIT];

  // Read data registered in the address phase; unmapped words read zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h0;
    end else if (a_rd) begin
      case (idx_nxt)
        sio_pkg::CTRL_IDX: hrdata <= {24'h0, ctrl_r.start, 1'b0, ctrl_r.mode,
                                      ctrl_r.lsb_first, ctrl_r.sel};
        sio_pkg::STAT_IDX: hrdata <= {24'h0, stat_r.busy, stat_r.partial,
                                      stat_r.tx_empty, rx_full_r,
                                      stat_r.tx_err, 3'h0};
        sio_pkg::BUF_IDX: hrdata <= {24'h0, rx_buf_r};
        sio_pkg::SPEED_IDX: hrdata <= {30'h0, low_speed_r, div_src_r};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Control and speed registers; stop bit is never stored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= sio_pkg::ctrl_t'(7'h00);
      div_src_r <= 1'b0;
      low_speed_r <= 1'b0;
    end else begin
      if (force_stop) begin
        ctrl_r.start <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_r.start <= hwdata[sio_pkg::CTRL_START_BIT];
        ctrl_r.mode <= hwdata[sio_pkg::CTRL_MODE_LSB +: 2];
        ctrl_r.lsb_first <= hwdata[sio_pkg::CTRL_DIR_BIT];
        ctrl_r.sel <= hwdata[sio_pkg::CTRL_SEL_LSB +: 3];
      end
      if (wr_hit(a_wr_r, a_idx_r, sio_pkg::SPEED_IDX)) begin
        div_src_r <= hwdata[sio_pkg::SPEED_DIV_BIT];
        low_speed_r <= hwdata[sio_pkg::SPEED_SLOW_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial clock: external pin synchroniser and internal generator
  // ----------------------------------------------------------------------
  logic ext_mode;
  logic tx_mode;
  assign ext_mode = (ctrl_r.sel == sio_pkg::SEL_EXT);
  // Only mode 00B shifts data out
  assign tx_mode = (ctrl_r.mode == sio_pkg::MODE_TX);

  logic sck_m_r;
  logic sck_s_r;
  logic sck_d_r;
  // Pulse widths of 4/fc survive the two-stage sampling
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sck_m_r <= 1'b1;
      sck_s_r <= 1'b1;
      sck_d_r <= 1'b1;
    end else begin
      sck_m_r <= sck_in;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
    end
  end

  // Half period in fc cycles for the selected internal rate
  function automatic logic [19:0] half_cycles(input logic [2:0] sel,
                                              input logic dv, input logic slow,
                                              input logic [19:0] fs_half);
    if (sel == sio_pkg::SEL_SLOWEST) begin
      half_cycles = (dv || slow) ? fs_half : 20'(sio_pkg::SLOWEST_HALF);
    end else begin
      half_cycles = 20'(1) << (4'(sio_pkg::FAST_SHIFT) - {1'b0, sel});
    end
  endfunction

  localparam logic [19:0] FS_HALF = 20'(FS_DIV * sio_pkg::FS_HALF_MULT);
  logic [19:0] half_len;
  logic [19:0] gen_cnt_r;
  logic gen_sck_r;
  logic gen_halt;
  logic gen_tick;
  logic [2:0] bit_cnt_r;
  logic byte_edge;
  assign half_len = half_cycles(ctrl_r.sel, div_src_r, low_speed_r, FS_HALF);
  // Next edge would start a byte: only allowed with data and start set
  assign byte_edge = (bit_cnt_r == 3'h0);
  // Halt while high at a byte boundary without data
  assign gen_halt = ext_mode || !tx_mode || stat_r.tx_err ||
                    (gen_sck_r && byte_edge &&
                     (stat_r.tx_empty || !ctrl_r.start));
  assign gen_tick = (gen_cnt_r == half_len - 20'h1);

  // Internal divider; held at zero while halted so the restart takes
  // half a serial period, well inside one full period
  always_ff @(posedge ref_clk) begin
    if (reset || force_stop) begin
      gen_cnt_r <= 20'h0;
      gen_sck_r <= 1'b1;
    end else if (gen_halt) begin
      gen_cnt_r <= 20'h0;
      gen_sck_r <= 1'b1;
    end else if (gen_tick) begin
      gen_cnt_r <= 20'h0;
      gen_sck_r <= !gen_sck_r;
    end else begin
      gen_cnt_r <= gen_cnt_r + 20'h1;
    end
  end

  // Pin drive only for internal codes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      sck_out <= gen_sck_r;
      sck_oe <= !ext_mode;
    end
  end

  logic fall_ev;
  logic rise_ev;
  // Leading edge is the fall, trailing edge the rise
  assign fall_ev = ext_mode ? (sck_d_r && !sck_s_r)
                            : (gen_tick && !gen_halt && gen_sck_r);
  assign rise_ev = ext_mode ? (!sck_d_r && sck_s_r)
                            : (gen_tick && !gen_halt && !gen_sck_r);

  // ----------------------------------------------------------------------
  // Transmit shifter and status
  // ----------------------------------------------------------------------
  logic [7:0] shift_r;
  logic load_pend_r;
  logic irq_pend_r;
  logic buf_ok;
  // Writes only land while the buffer is empty
  assign buf_ok = wr_buf && stat_r.tx_empty;

  // Buffered byte
  always_ff @(posedge ref_clk) begin
    if (reset || force_stop) begin
      tx_buf_r <= sio_pkg::BUF_RESET;
    end else if (buf_ok) begin
      tx_buf_r <= hwdata[7:0];
    end
  end

  // Order-aware head bit of a byte
  function automatic logic head_bit(input logic [7:0] d, input logic lsb);
    head_bit = lsb ? d[0] : d[7];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset || force_stop) begin
      shift_r <= 8'h0;
      bit_cnt_r <= 3'h0;
      serial_out_pin <= 1'b1;
    end else if (fall_ev && tx_mode) begin
      if (!byte_edge) begin
        shift_r <= ctrl_r.lsb_first ? {1'b0, shift_r[7:1]} : {shift_r[6:0], 1'b0};
        serial_out_pin <= ctrl_r.lsb_first ? shift_r[1] : shift_r[6];
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end else if (ctrl_r.start && !stat_r.tx_empty && !stat_r.tx_err) begin
        // Load on the first fall of the byte
        shift_r <= tx_buf_r;
        serial_out_pin <= head_bit(tx_buf_r, ctrl_r.lsb_first);
        bit_cnt_r <= 3'h1;
      end else begin
        // Underrun or stop: line rests high
        serial_out_pin <= 1'b1;
      end
    end
  end

  logic loading;
  logic underrun;
  assign loading = fall_ev && tx_mode && byte_edge && ctrl_r.start &&
                   !stat_r.tx_empty && !stat_r.tx_err;
  // A standing error raises one request, not one on every later edge
  assign underrun = fall_ev && tx_mode && byte_edge && ctrl_r.start &&
                    stat_r.tx_empty && ext_mode && !stat_r.tx_err;

  // Status flags; hardware sets win over software clears other than the stop write
  always_ff @(posedge ref_clk) begin
    if (reset || force_stop) begin
      stat_r <= '{busy: 1'b0, partial: 1'b0, tx_empty: 1'b1, tx_err: 1'b0};
      load_pend_r <= 1'b0;
    end else begin
      // Busy on the first fall after start
      if (fall_ev && tx_mode && ctrl_r.start) begin
        stat_r.busy <= 1'b1;
      end else if (rise_ev && byte_edge && !ctrl_r.start) begin
        stat_r.busy <= 1'b0;
      end else if (!ctrl_r.start && byte_edge && gen_halt && !ext_mode) begin
        stat_r.busy <= 1'b0;
      end
      // High from fall one until fall eight clears it
      if (fall_ev && tx_mode) begin
        stat_r.partial <= loading || (!byte_edge && bit_cnt_r != 3'h7);
      end
      // Empty flag on the rise after the load
      if (loading) begin
        load_pend_r <= 1'b1;
      end else if (rise_ev && load_pend_r) begin
        load_pend_r <= 1'b0;
      end
      if (rise_ev && load_pend_r) begin
        stat_r.tx_empty <= 1'b1;
      end else if (buf_ok) begin
        stat_r.tx_empty <= 1'b0;
      end
      // Underrun sticky, cleared by writing zero
      if (underrun) begin
        stat_r.tx_err <= 1'b1;
      end else if (wr_stat && !hwdata[sio_pkg::STAT_TX_UNDERRUN_FLAG_BIT]) begin
        stat_r.tx_err <= 1'b0;
      end
    end
  end

  // Request pulse one fall after the empty flag or the error sets
  always_ff @(posedge ref_clk) begin
    if (reset || force_stop) begin
      irq_pend_r <= 1'b0;
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= fall_ev && irq_pend_r;
      // Arm on flag set, fire on the next fall
      if ((rise_ev && load_pend_r) || underrun) begin
        irq_pend_r <= 1'b1;
      end else if (fall_ev) begin
        irq_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive sampling on the trailing edge of the external clock (outside transmit-only mode)
  // ----------------------------------------------------------------------
  logic [7:0] rx_shift_r;
  logic si_m_r;
  logic si_s_r;
  logic [2:0] rx_cnt_r;
  // Data pin passes two flops like any outside level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      si_m_r <= 1'b1;
      si_s_r <= 1'b1;
    end else begin
      si_m_r <= serial_in_pin;
      si_s_r <= si_m_r;
    end
  end

  // Sample on the rise; transmit-only mode ignores the input
  always_ff @(posedge ref_clk) begin
    if (reset || force_stop) begin
      rx_shift_r <= 8'h0;
      rx_cnt_r <= 3'h0;
      rx_buf_r <= sio_pkg::BUF_RESET;
      rx_full_r <= 1'b0;
    end else if (rise_ev && !tx_mode && ctrl_r.start) begin
      rx_shift_r <= ctrl_r.lsb_first ? {si_s_r, rx_shift_r[7:1]}
                                     : {rx_shift_r[6:0], si_s_r};
      rx_cnt_r <= rx_cnt_r + 3'h1;
      if (rx_cnt_r == 3'h7) begin
        rx_buf_r <= ctrl_r.lsb_first ? {si_s_r, rx_shift_r[7:1]}
                                     : {rx_shift_r[6:0], si_s_r};
        rx_full_r <= 1'b1;
      end
    end else if (a_rd && idx_nxt == sio_pkg::BUF_IDX) begin
      rx_full_r <= 1'b0;
    end
  end
endmodule

// ### src/sio_pkg.sv
// Constants, register map and carrier types of the synchronous serial port.
// Assumes a 250 MHz system clock that also serves as the high-speed clock fc.
package sio_pkg;
  // ----------------------------------------------------------------------
  // Register map: word indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] BUF_IDX = 8'h2b;
  localparam logic [7:0] SPEED_IDX = 8'h30;
  localparam logic [7:0] CTRL_IDX = 8'h31;
  localparam logic [7:0] STAT_IDX = 8'h32;
  // Control field positions
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_STOP_BIT = 6;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CTRL_SEL_LSB = 0;
  // Status field positions
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_PART_BIT = 6;
  localparam int STAT_TXE_BIT = 5;
  localparam int STAT_RXF_BIT = 4;
  localparam int STAT_TX_UNDERRUN_FLAG_BIT = 3;
  localparam int STAT_RXERR_BIT = 2;
  // Speed register field positions
  localparam int SPEED_DIV_BIT = 0;
  localparam int SPEED_SLOW_BIT = 1;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;
  // Codes
  localparam logic [2:0] SEL_EXT = 3'h7;
  localparam logic [2:0] SEL_SLOWEST = 3'h0;
  localparam logic [1:0] MODE_TX = 2'h0;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ = 64'd250000000;
  localparam longint FS_HZ = 64'd32768;
  localparam int FS_DIV = int'(CLK_HZ / FS_HZ);
  localparam int SLOWEST_HALF = 2048;
  localparam int FS_HALF_MULT = 8;
  localparam int FAST_SHIFT = 8;
  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic [1:0] mode;
    logic lsb_first;
    logic [2:0] sel;
  } ctrl_t;
  typedef struct packed {
    logic busy;
    logic partial;
    logic tx_empty;
    logic tx_err;
  } stat_t;
endpackage

// ### verification/sio_peer.sv
// Far-side serial device: samples the data line and can supply the clock.
// Assumes the port's clock pin resolves from sck_out and sck_oe.
`timescale 1ns/1ps
module sio_peer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic data_in,
  input wire logic ext_run,
  input wire logic lsb_first,
  output logic sck_pin,
  output logic [7:0] rx_byte,
  output logic rx_tog
);
  // ------------------------------
  // Clock pin and byte capture
  // ------------------------------
  // Phases of six fc
  localparam int EXT_HALF = 6;
  logic ext_clk = 1'b1;
  int cnt = 0;
  int nbit = 0;
  logic [7:0] sh;
  // Pin follows the port while it drives, our clock otherwise
  assign sck_pin = sck_oe ? sck_out : ext_clk;
  // A started low phase is finished so the pin rests high
  always @(posedge ref_clk) begin
    if (ext_run || !ext_clk) begin
      cnt <= (cnt == EXT_HALF - 1) ? 0 : cnt + 1;
      if (cnt == EXT_HALF - 1) begin
        ext_clk <= !ext_clk;
      end
    end else begin
      cnt <= 0;
    end
  end
  // Sample on the rising edge; eight bits make a byte
  always @(posedge sck_pin or posedge rst) begin
    if (rst) begin
      nbit <= 0;
      rx_tog <= 1'b0;
    end else begin
      sh = lsb_first ? {data_in, sh[7:1]} : {sh[6:0], data_in};
      nbit <= (nbit == 7) ? 0 : nbit + 1;
      if (nbit == 7) begin
        rx_byte <= sh;
        rx_tog <= !rx_tog;
      end
    end
  end
endmodule

// ### verification/sio_tx_port_sva.sv
// Checker on the serial port's pins and bus answers.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sio_tx_port_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out_pin,
  input wire logic serial_irq
);
  // ------------------------------
  // Clock pin and answer checks
  // ------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic [11:0] low_cnt_r;
  // Cycles the driven clock stays low; a stuck wait shows here
  always_ff @(posedge ref_clk) begin
    if (reset || !sck_oe || sck_out) begin
      low_cnt_r <= 12'h0;
    end else begin
      low_cnt_r <= low_cnt_r + 12'h1;
    end
  end
  property p_rst_idle;
    $fell(reset) |-> sck_out && !sck_oe && serial_out_pin && !serial_irq;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
  property p_low_min;
    sck_oe && $fell(sck_out) |-> !sck_out [*4];
  endproperty
  a_low_min: assert property (p_low_min) else $error("low phase too short");
  property p_high_min;
    sck_oe && $rose(sck_out) |-> sck_out [*4];
  endproperty
  a_high_min: assert property (p_high_min) else $error("high phase too short");
  property p_low_max;
    low_cnt_r <= 12'h800;
  endproperty
  a_low_max: assert property (p_low_max) else $error("clock stuck low");
  property p_stable_rise;
    sck_oe && $rose(sck_out) |-> $stable(serial_out_pin) || serial_out_pin;
  endproperty
  a_stable_rise: assert property (p_stable_rise) else $error("data moved on rise");
  property p_irq_pulse;
    serial_irq |=> !serial_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request not a pulse");
  property p_oe_hold;
    sck_oe && !sck_out |=> sck_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive dropped mid clock");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
endmodule
bind sio_tx_port sio_tx_port_sva sio_tx_port_sva_inst (.ref_clk(ref_clk), .reset(reset),
  .hreadyout(hreadyout), .hresp(hresp), .sck_out(sck_out), .sck_oe(sck_oe),
  .serial_out_pin(serial_out_pin), .serial_irq(serial_irq));

// ### verification/sync_serial_clocking_and_transmit_test.sv
// Self-checking bench for the serial transmit port over AHB-Lite.
// Assumes sio_peer on the far side and the checker bound in its own file.
`timescale 1ns/1ps
module sync_serial_clocking_and_transmit_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_run = 1'b0;
  logic lsb = 1'b0;
  logic hreadyout, hresp, sck_out, sck_oe, sdo, serial_irq, sck_pin, rx_tog;
  logic [31:0] hrdata, rv;
  logic [7:0] rx_byte, b;
  logic [2:0] sel;
  logic [7:0] q[$];
  integer seed = 32'h7ece;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int irq_n = 0;
  int half;
  sio_tx_port #(.FS_DIV(4)) sio_tx_port_inst (.ref_clk(ref_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe),
    .serial_out_pin(sdo), .serial_in_pin(1'b1), .serial_irq(serial_irq));
  sio_peer sio_peer_inst (.ref_clk(ref_clk), .rst(reset), .sck_out(sck_out),
    .sck_oe(sck_oe), .data_in(sdo), .ext_run(ext_run), .lsb_first(lsb),
    .sck_pin(sck_pin), .rx_byte(rx_byte), .rx_tog(rx_tog));
  // ------------------------------
  // Helpers
  // ------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; the address phase is held until hready
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rv = hrdata;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e,
                    input string nm);
    bus(1'b0, idx, 8'h0);
    chk(nm, {24'h0, e & m}, rv & {24'hffffff, m});
  endtask
  // Poll one status bit; the bound only stops a hang
  task automatic wait_st(input int bn, input logic v);
    for (int i = 0; i < 30000; i++) begin
      bus(1'b0, sio_pkg::STAT_IDX, 8'h0);
      if (rv[bn] === v) break;
    end
  endtask
  // Length of the first driven low phase, in clock samples
  task automatic meas(output int h);
    h = 0;
    for (int i = 0; i < 5000 && sck_out !== 1'b0; i++) @(posedge ref_clk);
    while (sck_out === 1'b0 && h < 5000) begin
      @(posedge ref_clk);
      h++;
    end
  endtask
  // Eight external clocks; the peer ends every burst high
  task automatic run_ext();
    @(posedge ref_clk);
    ext_run <= 1'b1;
    repeat (96) @(posedge ref_clk);
    ext_run <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask
  // ------------------------------
  // Scoreboard, request count, timeout
  // ------------------------------
  always @(rx_tog) begin
    if (!reset && q.size() == 0) chk("extra byte", 0, 1);
    else if (!reset) chk("byte on wire", q.pop_front(), rx_byte);
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (serial_irq === 1'b1) irq_n++;
    if (cyc == 100000) begin
      n_errors++;
      results();
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(sio_pkg::STAT_IDX, 8'hfc, 8'h20, "status at reset");
    rd(sio_pkg::CTRL_IDX, 8'hff, 8'h00, "control at reset");
    bus(1'b1, 8'h10, 8'h5a);
    rd(8'h10, 8'hff, 8'h00, "unmapped");
    // Every internal rate, alternating bit order; 7 and 8 are the fs rates
    for (int s = 0; s < 9; s++) begin
      irq_n = 0;
      lsb <= s[0];
      sel = (s < 7) ? 3'(s) : 3'h0;
      bus(1'b1, sio_pkg::SPEED_IDX, (s == 7) ? 8'h1 : (s == 8) ? 8'h2 : 8'h0);
      bus(1'b1, sio_pkg::CTRL_IDX, {4'h8, s[0], sel});
      repeat (20) @(posedge ref_clk);
      chk("clock before data", 1, sck_out);
      b = 8'($random(seed));
      q.push_back(b);
      bus(1'b1, sio_pkg::BUF_IDX, b);
      meas(half);
      chk("half period", (s > 6) ? 32 : (s == 0) ? 2048 : 1 << (8 - s), half);
      rd(sio_pkg::STAT_IDX, 8'he0, 8'he0, "busy partial empty");
      if (s != 0) begin
        b = 8'($random(seed));
        q.push_back(b);
        bus(1'b1, sio_pkg::BUF_IDX, b);
        bus(1'b1, sio_pkg::BUF_IDX, ~b);
        rd(sio_pkg::STAT_IDX, 8'h20, 8'h00, "empty cleared");
        // The write of ~b while full is dropped; b itself loads at the next boundary while start is still high
        wait_st(5, 1'b1);
        chk("second byte loaded", 1, rv[5]);
      end
      bus(1'b1, sio_pkg::CTRL_IDX, {4'h0, s[0], sel});
      wait_st(7, 1'b0);
      chk("busy after stop", 0, rv[7]);
      chk("clock rests high", 1, sck_out);
      chk("request count", (s == 0) ? 1 : 2, irq_n);
      chk("bytes pending", 0, q.size());
    end
    // External clock: one byte, then an underrun
    irq_n = 0;
    lsb <= 1'b0;
    b = 8'($random(seed));
    q.push_back(b);
    bus(1'b1, sio_pkg::BUF_IDX, b);
    bus(1'b1, sio_pkg::CTRL_IDX, 8'h87);
    run_ext();
    q.push_back(8'hff);
    run_ext();
    rd(sio_pkg::STAT_IDX, 8'h08, 8'h08, "underrun flag");
    chk("error request", 2, irq_n);
    bus(1'b1, sio_pkg::STAT_IDX, 8'h08);
    rd(sio_pkg::STAT_IDX, 8'h08, 8'h08, "flag after one");
    bus(1'b1, sio_pkg::STAT_IDX, 8'h00);
    rd(sio_pkg::STAT_IDX, 8'h08, 8'h00, "flag after zero");
    bus(1'b1, sio_pkg::CTRL_IDX, 8'h40);
    rd(sio_pkg::CTRL_IDX, 8'hff, 8'h07, "control after force");
    rd(sio_pkg::STAT_IDX, 8'hfc, 8'h20, "status after force");
    chk("bytes left", 0, q.size());
    results();
  end
endmodule
